// >>> rtl/sdmr_pkg.sv
// Shared constants, types and helper functions of the mode register block.
package sdmr_pkg;
    localparam int ADDR_W = 13;
    localparam int COL_W  = 10;

    // Field positions inside the operating mode register.
    localparam int BL_LSB   = 0;
    localparam int BT_POS   = 3;
    localparam int CL_LSB   = 4;
    localparam int MODE_LSB = 7;
    localparam int DLL_BIT  = 8;

    // Value after reset; software must still load the register before use.
    localparam logic [12:0] MODE_REG_RESET = 13'h0000;

    // Burst length codes.
    localparam logic [2:0] BL_CODE_2 = 3'h1;
    localparam logic [2:0] BL_CODE_4 = 3'h2;
    localparam logic [2:0] BL_CODE_8 = 3'h3;

    // Read latency codes.
    localparam logic [2:0] CL_CODE_2  = 3'h2;
    localparam logic [2:0] CL_CODE_3  = 3'h3;
    localparam logic [2:0] CL_CODE_25 = 3'h6;

    // Operating mode codes.
    localparam logic [5:0] MODE_NORMAL    = 6'h00;
    localparam logic [5:0] MODE_DLL_RESET = 6'h02;

    // Full-clock counts of the latencies.
    localparam logic [1:0] CL_CLOCKS_2 = 2'h2;
    localparam logic [1:0] CL_CLOCKS_3 = 2'h3;

    typedef struct packed {
        logic [5:0] op_mode;
        logic [2:0] read_latency_field;
        logic       burst_order_field;
        logic [2:0] burst_len_field;
    } sdmr_mode_t;

    typedef struct packed {
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
    } sdmr_cmd_t;

    localparam logic [3:0] CMD_MRS   = 4'h0;
    localparam logic [3:0] CMD_READ  = 4'h5;
    localparam logic [3:0] CMD_WRITE = 4'h4;

    // Number of elements of a burst, zero for a reserved code.
    function automatic logic [3:0] burst_elems(input logic [2:0] code);
        case (code)
            BL_CODE_2: burst_elems = 4'h2;
            BL_CODE_4: burst_elems = 4'h4;
            BL_CODE_8: burst_elems = 4'h8;
            default:   burst_elems = 4'h0;
        endcase
    endfunction

    // Mask of the in-block offset bits for a burst length code.
    function automatic logic [2:0] burst_mask(input logic [2:0] code);
        case (code)
            BL_CODE_2: burst_mask = 3'h1;
            BL_CODE_4: burst_mask = 3'h3;
            BL_CODE_8: burst_mask = 3'h7;
            default:   burst_mask = 3'h0;
        endcase
    endfunction

    // Offset of element k inside the aligned block.
    function automatic logic [2:0] burst_offset(input logic [2:0] start,
                                                input logic [2:0] k,
                                                input logic       order,
                                                input logic [2:0] mask);
        logic [2:0] raw;
        raw = order ? (start ^ k) : (start + k);
        burst_offset = raw & mask;
    endfunction
endpackage

// >>> rtl/sdmr_burst_seq.sv
// Column address sequencer for one read or write burst.
`timescale 1ns/1ps
`default_nettype none
module sdmr_burst_seq (
    input  wire logic                     mclk,
    input  wire logic                     sys_rst,
    input  wire logic                     start,
    input  wire logic                     start_write,
    input  wire logic [sdmr_pkg::COL_W-1:0] start_col,
    input  wire logic [2:0]               blen_code,
    input  wire logic                     order,
    output logic      [sdmr_pkg::COL_W-1:0] col,
    output logic                          valid,
    output logic                          write
);
    logic [sdmr_pkg::COL_W-1:0] col_reg,   col_next;
    logic [sdmr_pkg::COL_W-1:0] base_reg,  base_next;
    logic [3:0]                 cnt_reg,   cnt_next;
    logic [3:0]                 len_reg,   len_next;
    logic [2:0]                 mask_reg,  mask_next;
    logic                       order_reg, order_next;
    logic                       valid_reg, valid_next;
    logic                       write_reg, write_next;
    logic [2:0]                 mask_in;

    always_comb begin
        mask_in    = sdmr_pkg::burst_mask(blen_code);
        col_next   = col_reg;
        base_next  = base_reg;
        cnt_next   = cnt_reg;
        len_next   = len_reg;
        mask_next  = mask_reg;
        order_next = order_reg;
        valid_next = valid_reg;
        write_next = write_reg;
        if (start) begin
            // A new command cuts any burst still running.
            base_next  = start_col;
            len_next   = sdmr_pkg::burst_elems(blen_code); // RQ5 RQ15
            mask_next  = mask_in; // RQ12
            order_next = order; // RQ6
            write_next = start_write; // RQ15
            col_next   = start_col;
            cnt_next   = 4'h1;
            valid_next = (sdmr_pkg::burst_elems(blen_code) != 4'h0);
        end else if (valid_reg) begin
            if (cnt_reg == len_reg) begin
                valid_next = 1'b0;
            end else begin
                // Upper bits stay those of the block, so the burst wraps inside it.
                col_next = {base_reg[sdmr_pkg::COL_W-1:3] , 3'h0}
                         | {{(sdmr_pkg::COL_W-3){1'b0}}, base_reg[2:0] & ~mask_reg}
                         | {{(sdmr_pkg::COL_W-3){1'b0}},
                            sdmr_pkg::burst_offset(base_reg[2:0], cnt_reg[2:0],
                                                   order_reg, mask_reg)}; // RQ13 RQ14
                cnt_next = cnt_reg + 4'h1;
            end
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            col_reg   <= '0;
            base_reg  <= '0;
            cnt_reg   <= 4'h0;
            len_reg   <= 4'h0;
            mask_reg  <= 3'h0;
            order_reg <= 1'b0;
            valid_reg <= 1'b0;
            write_reg <= 1'b0;
        end else begin
            col_reg   <= col_next;
            base_reg  <= base_next;
            cnt_reg   <= cnt_next;
            len_reg   <= len_next;
            mask_reg  <= mask_next;
            order_reg <= order_next;
            valid_reg <= valid_next;
            write_reg <= write_next;
        end
    end

    assign col   = col_reg;
    assign valid = valid_reg;
    assign write = write_reg;

    block_wrap_a: assert property (@(posedge mclk) disable iff (sys_rst) // RQ13
        valid_reg |-> ((col_reg[2:0] & ~mask_reg) == (base_reg[2:0] & ~mask_reg))
                      && (col_reg[sdmr_pkg::COL_W-1:3] == base_reg[sdmr_pkg::COL_W-1:3]))
        else $error("Burst left its aligned block.");

    seq_step_a: assert property (@(posedge mclk) disable iff (sys_rst) // RQ14
        (valid_reg && !order_reg && !start && cnt_reg != len_reg)
        |=> ((col_reg[2:0] & mask_reg) == (($past(col_reg[2:0]) + 3'h1) & mask_reg)))
        else $error("Sequential burst did not step by one.");

    ilv_step_a: assert property (@(posedge mclk) disable iff (sys_rst) // RQ14
        valid_reg && order_reg
        |-> (((col_reg[2:0] ^ base_reg[2:0]) & mask_reg) == ((cnt_reg[2:0] - 3'h1) & mask_reg)))
        else $error("Interleaved burst offset is not start xor count.");

    len8_a: assert property (@(posedge mclk) disable iff (sys_rst) // RQ5
        (start && blen_code == sdmr_pkg::BL_CODE_8) ##1 (!start)[*8]
        |-> valid_reg && $past(valid_reg, 7) ##1 !valid_reg)
        else $error("Burst of eight did not last eight cycles.");
endmodule
`default_nettype wire

// >>> rtl/sdmr_mode_register.sv
// Operating mode register with read latency timing and burst address order.
`timescale 1ns/1ps
`default_nettype none
// What this block and its controller do
// (RQ1) A mode load with both bank selects low loads the register from address.
// (RQ2) Fields hold until reloaded; the DLL reset bit clears itself after one cycle.
// (RQ3) Bits 2:0 length, 3 order, 6:4 latency, 12:7 operating mode.
// (RQ4) Controller loads only with banks idle and waits before the next command.
// (RQ5) Length codes 001, 010, 011 give 2, 4, 8 elements; others reserved.
// (RQ6) Order bit zero means sequential, one means interleaved, for all lengths.
// (RQ7) Latency codes 010, 011, 110 give 2, 3, 2.5 clocks; others reserved.
// (RQ8) First read data appears at edge n plus m for a read at edge n.
// (RQ9) Mode zero is normal, mode 000010 starts a DLL reset; low bits load anyway.
// (RQ10) After a DLL reset load the controller reloads with normal mode.
// (RQ11) The controller uses no other operating mode values.
// (RQ12) Column bits above the length select the block, low bits the start.
// (RQ13) A burst wraps inside its aligned block and never leaves it.
// (RQ14) Sequential steps upward modulo length; interleaved is start xor count.
// (RQ15) One programmed length and order serve reads and writes alike.
// (RQ16) The controller treats contents as undefined until the first load.
module sdmr_mode_register (
    input  wire logic                       mclk,
    input  wire logic                       sys_rst,
    input  wire sdmr_pkg::sdmr_cmd_t        cmd,
    input  wire logic                       bank_select_low,
    input  wire logic                       bank_select_high,
    input  wire logic [sdmr_pkg::ADDR_W-1:0] addr,
    output var sdmr_pkg::sdmr_mode_t        mode_out,
    output logic                            dll_reset_pulse,
    output logic                            bl_reserved,
    output logic                            cl_reserved,
    output logic                            rd_first_data,
    output logic                            rd_half_clock,
    output logic      [sdmr_pkg::COL_W-1:0] burst_col,
    output logic                            burst_valid,
    output logic                            burst_write
);
    logic [sdmr_pkg::ADDR_W-1:0] mode_reg,     mode_next;
    logic                        dll_pulse_reg, dll_pulse_next;
    logic                        bl_res_reg,    bl_res_next;
    logic                        cl_res_reg,    cl_res_next;
    logic [1:0]                  lat_cnt_reg,   lat_cnt_next;
    logic                        half_pend_reg, half_pend_next;
    logic                        rd_first_reg,  rd_first_next;
    logic                        rd_half_reg,   rd_half_next;
    logic                        mrs_cmd;
    logic                        mrs_hit;
    logic                        rd_cmd;
    logic                        wr_cmd;
    logic [2:0]                  cl_code;
    logic [2:0]                  bl_code;

    always_comb begin
        mrs_cmd = ({cmd.cs_n, cmd.ras_n, cmd.cas_n, cmd.we_n} == sdmr_pkg::CMD_MRS);
        mrs_hit = mrs_cmd && !bank_select_low && !bank_select_high; // RQ1
        rd_cmd  = ({cmd.cs_n, cmd.ras_n, cmd.cas_n, cmd.we_n} == sdmr_pkg::CMD_READ);
        wr_cmd  = ({cmd.cs_n, cmd.ras_n, cmd.cas_n, cmd.we_n} == sdmr_pkg::CMD_WRITE);
        bl_code = mode_reg[sdmr_pkg::BL_LSB +: 3]; // RQ3
        cl_code = mode_reg[sdmr_pkg::CL_LSB +: 3]; // RQ3
    end

    // Mode register and its status flags.
    always_comb begin
        mode_next      = mode_reg;
        dll_pulse_next = 1'b0;
        // The DLL reset bit is a one-shot; the rest of the word is kept.
        mode_next[sdmr_pkg::DLL_BIT] = 1'b0; // RQ2
        if (mrs_hit) begin
            // All thirteen bits are taken as supplied, whatever the mode.
            mode_next      = addr; // RQ1 RQ9
            dll_pulse_next = (addr[sdmr_pkg::MODE_LSB +: 6] == sdmr_pkg::MODE_DLL_RESET); // RQ9
        end
        bl_res_next = (sdmr_pkg::burst_elems(mode_next[sdmr_pkg::BL_LSB +: 3]) == 4'h0); // RQ5
        case (mode_next[sdmr_pkg::CL_LSB +: 3])
            sdmr_pkg::CL_CODE_2,
            sdmr_pkg::CL_CODE_3,
            sdmr_pkg::CL_CODE_25: cl_res_next = 1'b0; // RQ7
            default:              cl_res_next = 1'b1;
        endcase
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            mode_reg      <= sdmr_pkg::MODE_REG_RESET;
            dll_pulse_reg <= 1'b0;
            bl_res_reg    <= 1'b1;
            cl_res_reg    <= 1'b1;
        end else begin
            mode_reg      <= mode_next;
            dll_pulse_reg <= dll_pulse_next;
            bl_res_reg    <= bl_res_next;
            cl_res_reg    <= cl_res_next;
        end
    end

    // Read latency timing. A reserved latency gives no data strobe at all,
    // since guessing a figure would hide a programming error.
    always_comb begin
        lat_cnt_next   = lat_cnt_reg;
        half_pend_next = half_pend_reg;
        rd_first_next  = 1'b0;
        rd_half_next   = 1'b0;
        if (lat_cnt_reg != 2'h0) begin
            lat_cnt_next = lat_cnt_reg - 2'h1;
            if (lat_cnt_reg == 2'h1) begin
                rd_first_next = 1'b1; // RQ8
                rd_half_next  = half_pend_reg;
            end
        end
        if (rd_cmd) begin
            case (cl_code)
                sdmr_pkg::CL_CODE_2: begin
                    lat_cnt_next   = sdmr_pkg::CL_CLOCKS_2; // RQ7 RQ8
                    half_pend_next = 1'b0;
                end
                sdmr_pkg::CL_CODE_3: begin
                    lat_cnt_next   = sdmr_pkg::CL_CLOCKS_3; // RQ7 RQ8
                    half_pend_next = 1'b0;
                end
                sdmr_pkg::CL_CODE_25: begin
                    // Half a clock later than two full clocks.
                    lat_cnt_next   = sdmr_pkg::CL_CLOCKS_2; // RQ7 RQ8
                    half_pend_next = 1'b1;
                end
                default: begin
                    lat_cnt_next   = 2'h0;
                    half_pend_next = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            lat_cnt_reg   <= 2'h0;
            half_pend_reg <= 1'b0;
            rd_first_reg  <= 1'b0;
            rd_half_reg   <= 1'b0;
        end else begin
            lat_cnt_reg   <= lat_cnt_next;
            half_pend_reg <= half_pend_next;
            rd_first_reg  <= rd_first_next;
            rd_half_reg   <= rd_half_next;
        end
    end

    // Reads and writes share the same burst settings.
    sdmr_burst_seq sdmr_burst_seq_i (
        .mclk        (mclk),
        .sys_rst     (sys_rst),
        .start       (rd_cmd || wr_cmd), // RQ15
        .start_write (wr_cmd),
        .start_col   (addr[sdmr_pkg::COL_W-1:0]), // RQ12
        .blen_code   (bl_code),
        .order       (mode_reg[sdmr_pkg::BT_POS]), // RQ6
        .col         (burst_col),
        .valid       (burst_valid),
        .write       (burst_write)
    );

    assign mode_out        = sdmr_pkg::sdmr_mode_t'(mode_reg); // RQ3
    assign dll_reset_pulse = dll_pulse_reg;
    assign bl_reserved     = bl_res_reg;
    assign cl_reserved     = cl_res_reg;
    assign rd_first_data   = rd_first_reg;
    assign rd_half_clock   = rd_half_reg;

    mode_load_a: assert property (@(posedge mclk) disable iff (sys_rst) // RQ1
        mrs_hit |=> (mode_reg[12:9] == $past(addr[12:9])) && (mode_reg[7:0] == $past(addr[7:0])))
        else $error("Mode load did not take the address.");

    bank_guard_a: assert property (@(posedge mclk) disable iff (sys_rst) // RQ1
        (mrs_cmd && (bank_select_low || bank_select_high)) |=> $stable(mode_reg[7:0]))
        else $error("Mode register changed on another bank select.");

    field_hold_a: assert property (@(posedge mclk) disable iff (sys_rst) // RQ2
        !mrs_hit |=> $stable(mode_reg[12:9]) && $stable(mode_reg[7:0]))
        else $error("Mode field changed without a load.");

    dll_clear_a: assert property (@(posedge mclk) disable iff (sys_rst) // RQ2
        (mode_reg[sdmr_pkg::DLL_BIT] && !mrs_hit) |=> !mode_reg[sdmr_pkg::DLL_BIT])
        else $error("DLL reset bit did not clear itself.");

    dll_pulse_a: assert property (@(posedge mclk) disable iff (sys_rst) // RQ9
        (mrs_hit && addr[12:7] == sdmr_pkg::MODE_DLL_RESET) ##1 !mrs_hit
        |-> dll_reset_pulse ##1 !dll_reset_pulse)
        else $error("DLL reset pulse missing or too long.");

    dll_bit_a: assert property (@(posedge mclk) disable iff (sys_rst) // RQ2
        dll_reset_pulse |-> mode_reg[sdmr_pkg::DLL_BIT])
        else $error("DLL reset pulse without the DLL reset bit.");

    lat_three_a: assert property (@(posedge mclk) disable iff (sys_rst) // RQ8
        (rd_cmd && cl_code == sdmr_pkg::CL_CODE_3) ##1 (!rd_cmd)[*2]
        |=> !rd_first_data ##1 (rd_first_data && !rd_half_clock))
        else $error("Read data not at edge n plus three.");

    lat_half_a: assert property (@(posedge mclk) disable iff (sys_rst) // RQ7
        (rd_cmd && cl_code == sdmr_pkg::CL_CODE_25) ##1 !rd_cmd
        |=> !rd_first_data ##1 (rd_first_data && rd_half_clock))
        else $error("Latency 2.5 not marked at edge n plus two.");

    half_pair_a: assert property (@(posedge mclk) disable iff (sys_rst) // RQ7
        rd_half_clock |-> rd_first_data)
        else $error("Half clock flag without a data strobe.");

    burst_resv_a: assert property (@(posedge mclk) disable iff (sys_rst) // RQ5
        ((rd_cmd || wr_cmd) && bl_reserved) |=> !burst_valid)
        else $error("Reserved burst length started a burst.");

    lat_resv_a: assert property (@(posedge mclk) disable iff (sys_rst) // RQ7
        (rd_cmd && cl_reserved && lat_cnt_reg == 2'h0) ##1 !rd_cmd |=> !rd_first_data)
        else $error("Reserved latency produced a data strobe.");
endmodule
`default_nettype wire

// >>> verification/sdmr_ctl_model.sv
// Behavioural memory controller that drives commands into the mode register block.
`timescale 1ns/1ps
`default_nettype none
module sdmr_ctl_model (
    input  wire logic                        mclk,
    output var  sdmr_pkg::sdmr_cmd_t         cmd,
    output logic                             bank_select_low,
    output logic                             bank_select_high,
    output logic [sdmr_pkg::ADDR_W-1:0]      addr
);
    // Pins idle as deselect until the first load, since contents are undefined before it.
    initial begin
        cmd = sdmr_pkg::sdmr_cmd_t'(4'hf);
        bank_select_low = 1'b1;
        bank_select_high = 1'b1;
        addr = 13'h1fff;
    end

    // One command for one cycle, then deselect; every bank is always idle here.
    task automatic issue(input logic [3:0] code, input logic [1:0] banks,
                         input logic [sdmr_pkg::ADDR_W-1:0] value);
        @(posedge mclk);
        cmd <= sdmr_pkg::sdmr_cmd_t'(code);
        bank_select_high <= banks[1];
        bank_select_low <= banks[0];
        addr <= value;
        @(posedge mclk);
        // Released bank selects and address show the inverse so a stale value is never mistaken for a hold.
        cmd <= sdmr_pkg::sdmr_cmd_t'(4'hf);
        bank_select_high <= ~banks[1];
        bank_select_low <= ~banks[0];
        addr <= ~value;
    endtask

    // Only normal operation or a DLL reset ever reaches the operating mode field.
    task automatic mode_load(input logic [6:0] low, input logic dll);
        issue(sdmr_pkg::CMD_MRS, 2'h0,
              {(dll ? sdmr_pkg::MODE_DLL_RESET : sdmr_pkg::MODE_NORMAL), low});
        if (dll) begin
            issue(sdmr_pkg::CMD_MRS, 2'h0, {sdmr_pkg::MODE_NORMAL, low});
        end
    endtask
endmodule
`default_nettype wire

// >>> verification/sdmr_mode_register_tb.sv
// Self-checking bench of the mode register block.
`timescale 1ns/1ps
`default_nettype none
`define CHK(what, exp, got) begin checks_done++; if ((got) !== (exp)) begin mismatches++; \
    $display("[ERR] %s expected %0h seen %0h", what, exp, got); end end
module sdmr_mode_register_tb;
    typedef struct {int cyc; logic [9:0] col; logic wr;} sdmr_note_t;
    logic                          mclk;
    logic                          sys_rst;
    sdmr_pkg::sdmr_cmd_t           cmd;
    logic                          bank_select_low;
    logic                          bank_select_high;
    logic [sdmr_pkg::ADDR_W-1:0]   addr;
    sdmr_pkg::sdmr_mode_t          mode_out;
    logic                          dll_reset_pulse;
    logic                          bl_reserved;
    logic                          cl_reserved;
    logic                          rd_first_data;
    logic                          rd_half_clock;
    logic [sdmr_pkg::COL_W-1:0]    burst_col;
    logic                          burst_valid;
    logic                          burst_write;
    int                            cyc = 0;
    int                            mismatches = 0;
    int                            checks_done = 0;
    sdmr_note_t                    rdq[$];
    sdmr_note_t                    bq[$];
    sdmr_note_t                    rn;
    sdmr_note_t                    bn;
    logic [2:0]                    cur_bl;
    logic [2:0]                    cur_cl;
    logic                          cur_bt;
    logic [2:0] bl_tab [8] = '{3'h1, 3'h2, 3'h3, 3'h0, 3'h7, 3'h3, 3'h2, 3'h1};
    logic [2:0] cl_tab [8] = '{3'h2, 3'h3, 3'h6, 3'h0, 3'h7, 3'h6, 3'h3, 3'h2};

    sdmr_mode_register sdmr_mode_register_i (
        .mclk(mclk), .sys_rst(sys_rst), .cmd(cmd), .bank_select_low(bank_select_low),
        .bank_select_high(bank_select_high), .addr(addr), .mode_out(mode_out),
        .dll_reset_pulse(dll_reset_pulse), .bl_reserved(bl_reserved),
        .cl_reserved(cl_reserved), .rd_first_data(rd_first_data),
        .rd_half_clock(rd_half_clock), .burst_col(burst_col), .burst_valid(burst_valid),
        .burst_write(burst_write)
    );
    sdmr_ctl_model sdmr_ctl_model_i (
        .mclk(mclk), .cmd(cmd), .bank_select_low(bank_select_low),
        .bank_select_high(bank_select_high), .addr(addr)
    );

    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    always @(posedge mclk) begin
        cyc <= cyc + 1;
    end

    // Results are judged mid-cycle, when every registered output has settled.
    always @(negedge mclk) begin
        if (rd_first_data === 1'b1) begin
            if (rdq.size() == 0) begin
                `CHK("unexpected read pulse", 1'b0, rd_first_data)
            end else begin
                rn = rdq.pop_front();
                `CHK("first data cycle", rn.cyc, cyc)
                `CHK("half clock flag", rn.wr, rd_half_clock)
            end
        end
        if (burst_valid === 1'b1) begin
            if (bq.size() == 0) begin
                `CHK("unexpected burst element", 1'b0, burst_valid)
            end else begin
                bn = bq.pop_front();
                `CHK("burst element cycle", bn.cyc, cyc)
                `CHK("burst column", bn.col, burst_col)
                `CHK("burst direction", bn.wr, burst_write)
            end
        end
    end

    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic drain();
        int t;
        t = 0;
        while (rdq.size() + bq.size() != 0 && t < 20) begin
            @(negedge mclk);
            t++;
        end
        if (rdq.size() + bq.size() != 0) begin
            mismatches++;
            $display("[ERR] pending results expected 0 seen %0d", rdq.size() + bq.size());
            conclude();
        end
        repeat (2) @(negedge mclk);
    endtask

    task automatic load_check();
        logic [12:0] val;
        val = {6'h00, cur_cl, cur_bt, cur_bl};
        @(negedge mclk);
        sdmr_ctl_model_i.mode_load(val[6:0], 1'b0);
        @(negedge mclk);
        `CHK("mode load", val, mode_out)
        `CHK("length reserved", !(cur_bl inside {3'h1, 3'h2, 3'h3}), bl_reserved)
        `CHK("latency reserved", !(cur_cl inside {3'h2, 3'h3, 3'h6}), cl_reserved)
    endtask

    // Expected order: the aligned block stays fixed, the offset steps or is xored.
    task automatic access(input logic wr);
        int len, off0, off, n, m;
        logic [9:0] col;
        @(negedge mclk);
        col = 10'($urandom);
        n = cyc + 2;
        len = (cur_bl == 3'h1) ? 2 : (cur_bl == 3'h2) ? 4 : (cur_bl == 3'h3) ? 8 : 0;
        off0 = (len == 0) ? 0 : int'(col) % len;
        for (int k = 0; k < len; k++) begin
            off = cur_bt ? (off0 ^ k) : (off0 + k) % len;
            bq.push_back('{n + k, 10'(int'(col) - off0 + off), wr});
        end
        m = (cur_cl == 3'h3) ? 3 : (cur_cl == 3'h2 || cur_cl == 3'h6) ? 2 : 0;
        if (!wr && m != 0) begin
            rdq.push_back('{n + m, 10'h000, cur_cl == 3'h6});
        end
        sdmr_ctl_model_i.issue(wr ? sdmr_pkg::CMD_WRITE : sdmr_pkg::CMD_READ, 2'h0,
                               {3'h0, col});
        drain();
    endtask

    initial begin
        sys_rst = 1'b1;
        void'($urandom(82));
        repeat (10) @(posedge mclk);
        `CHK("reset mode", 13'h0000, mode_out)
        `CHK("reset reserved flags", 2'h3, {bl_reserved, cl_reserved})
        sys_rst <= 1'b0;
        for (int i = 0; i < 16; i++) begin
            cur_bl = bl_tab[i % 8];
            cur_cl = cl_tab[i % 8];
            cur_bt = (i >= 8);
            load_check();
            access(1'b0);
            access(1'b1);
            `CHK("mode held", {6'h00, cur_cl, cur_bt, cur_bl}, mode_out)
        end
        @(negedge mclk);
        fork
            sdmr_ctl_model_i.mode_load(7'h32, 1'b1);
            begin
                repeat (2) @(negedge mclk);
                `CHK("dll pulse", 1'b1, dll_reset_pulse)
                `CHK("dll load", 13'h0132, mode_out)
                @(negedge mclk);
                `CHK("dll pulse end", 1'b0, dll_reset_pulse)
                `CHK("dll bit cleared", 13'h0032, mode_out)
            end
        join
        // A load with either bank select high goes to another register.
        for (int b = 1; b < 4; b++) begin
            @(negedge mclk);
            sdmr_ctl_model_i.issue(sdmr_pkg::CMD_MRS, 2'(b), 13'h1fcd);
            @(negedge mclk);
            `CHK("bank select refused", 13'h0032, mode_out)
        end
        drain();
        conclude();
    end
endmodule
`default_nettype wire
